// >>> cpl_pkg.sv
// Constants and types for the clock chip control and status pin logic
// Function
// R01: Address-one pin is address input for I2C, serial data out in four-wire SPI.
// R02: Serial clock is only an input from the host; never driven here.
// R03: Address-zero pin is I2C address bit, else active-low SPI select, pulled high.
// R04: Interrupt output driven low, push-pull, when device status changes.
// R05: Power-down input low puts the device in low-power mode; pulled high.
// R06: Reset input low returns all logic and settings to defaults.
// R07: Clock outputs stay disabled for as long as reset is held.
// R08: Output-enable input high disables all clock outputs; pulled low.
// R09: Lock indicator high while the loop is locked, low otherwise.
// R10: Active-low sync input resets output dividers; pulled high.
// R11: In manual mode the two select pins choose the active reference input.
// R12: Select pins decode as binary index; zero picks the first input.
// R13: Mode select high picks I2C, low picks SPI; pulled high.
// R14: Data pin two-way in I2C and three-wire SPI, input only in four-wire SPI.
package cpl_pkg;

    localparam int CPL_PIN_W = 11;
    localparam int CPL_I2C_SEL = 0;
    localparam int CPL_SCLK = 1;
    localparam int CPL_DATA = 2;
    localparam int CPL_ADDR1 = 3;
    localparam int CPL_ADDR0_CS = 4;
    localparam int CPL_PDN = 5;
    localparam int CPL_RST = 6;
    localparam int CPL_OE = 7;
    localparam int CPL_SYNC = 8;
    localparam int CPL_INSEL0 = 9;
    localparam int CPL_INSEL1 = 10;

    // Levels the pull resistors give an open pin
    localparam logic [CPL_PIN_W-1:0] CPL_PIN_RESET = 11'h177;

    localparam int CPL_STATUS_W = 4;
    localparam int CPL_REF_IDX_W = 2;
    localparam int CPL_NUM_REFS = 4;
    localparam logic [CPL_STATUS_W-1:0] CPL_STATUS_RESET = 4'h0;
    localparam logic [CPL_NUM_REFS-1:0] CPL_REF_RESET = 4'h1;

    typedef enum logic [2:0] {
        st_reset = 3'h1,
        st_run = 3'h2,
        st_power_down = 3'h4
    } cpl_state_type;

endpackage

// >>> cpl_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module cpl_pin_sync
    import cpl_pkg::*;
#(
    parameter int WIDTH = CPL_PIN_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = CPL_PIN_RESET
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic filt;
        logic next_filt;

        // Only a level seen by both late stages counts
        always_comb begin
            next_filt = (s2 == s3) ? s3 : filt;
        end

        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                s1 <= RESET_VALUE[i];
                s2 <= RESET_VALUE[i];
                s3 <= RESET_VALUE[i];
                filt <= RESET_VALUE[i];
            end else begin
                s1 <= pin[i];
                s2 <= s1;
                s3 <= s2;
                filt <= next_filt;
            end
        end

        assign level[i] = filt;
    end

endmodule
`default_nettype wire

// >>> cpl_irq_ctrl.sv
// Status change detector driving the active-low interrupt
`timescale 1ns/10ps
`default_nettype none
module cpl_irq_ctrl
    import cpl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic soft_rst,
    input wire logic [CPL_STATUS_W-1:0] status,
    input wire logic [CPL_STATUS_W-1:0] clear,
    output logic [CPL_STATUS_W-1:0] pending,
    output logic irq_n
);

    logic [CPL_STATUS_W-1:0] prev;
    logic [CPL_STATUS_W-1:0] change;
    logic [CPL_STATUS_W-1:0] next_prev;
    logic [CPL_STATUS_W-1:0] next_pending;
    logic next_irq_n;

    always_comb begin
        change = status ^ prev;
        next_prev = status;
        // A change in the clearing cycle still sets the bit
        next_pending = (pending & ~clear) | change; // R04
        next_irq_n = ~(|next_pending); // R04
        if (soft_rst) begin
            next_prev = status;
            next_pending = CPL_STATUS_RESET; // R06
            next_irq_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prev <= CPL_STATUS_RESET;
            pending <= CPL_STATUS_RESET;
            irq_n <= 1'b1;
        end else begin
            prev <= next_prev;
            pending <= next_pending;
            irq_n <= next_irq_n;
        end
    end

    AST_IRQ_ON_CHANGE: assert property (@(posedge ref_clk) disable iff (!resetn) // R04
        (|change && !soft_rst) |=> !irq_n)
        else $error("Status change did not pull the interrupt low");

    AST_IRQ_HOLDS: assert property (@(posedge ref_clk) disable iff (!resetn) // R04
        (!irq_n && (pending & ~clear) != 4'h0 && !soft_rst) |=> !irq_n)
        else $error("Interrupt released while a change was still pending");

endmodule
`default_nettype wire

// >>> cpl_pin_ctrl.sv
// Control and status pin logic of the clock chip, with serial port pin muxing
`timescale 1ns/10ps
`default_nettype none
module cpl_pin_ctrl
    import cpl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic i2c_select,
    input wire logic sclk_pin,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    input wire logic addr1_or_serial_out_in,
    output logic addr1_or_serial_out_out,
    output logic addr1_or_serial_out_oe,
    input wire logic addr0_or_chip_select_n,
    input wire logic power_down_n,
    input wire logic device_reset_n,
    input wire logic output_enable_n,
    input wire logic output_sync_n,
    input wire logic [CPL_REF_IDX_W-1:0] in_sel,
    input wire logic manual_ref_mode,
    input wire logic spi_four_wire,
    input wire logic [CPL_REF_IDX_W-1:0] core_ref_index,
    input wire logic core_pll_locked,
    input wire logic [CPL_STATUS_W-1:0] core_status,
    input wire logic [CPL_STATUS_W-1:0] irq_clear,
    input wire logic core_tx_data,
    input wire logic core_tx_en,
    output logic irq_n,
    output logic [CPL_STATUS_W-1:0] irq_pending,
    output logic pll_locked_flag,
    output logic clk_out_disable,
    output logic low_power_mode,
    output logic divider_reset,
    output logic [CPL_NUM_REFS-1:0] ref_select,
    output logic logic_reset,
    output logic ser_i2c_mode,
    output logic ser_spi_selected,
    output logic ser_sclk,
    output logic ser_sdi,
    output logic [1:0] ser_addr
);

    logic [CPL_PIN_W-1:0] pins;
    logic [CPL_PIN_W-1:0] lvl;
    logic soft_rst;
    logic i2c_mode;
    logic cs_active;
    logic [CPL_REF_IDX_W-1:0] sel_index;

    cpl_state_type state;
    cpl_state_type next_state;

    logic next_pll_locked_flag;
    logic next_clk_out_disable;
    logic next_low_power_mode;
    logic next_divider_reset;
    logic [CPL_NUM_REFS-1:0] next_ref_select;
    logic next_data_pin_out;
    logic next_data_pin_oe;
    logic next_addr1_out;
    logic next_addr1_oe;

    // Serial clock stays an input only; no driver exists for it
    always_comb begin
        pins = '0;
        pins[CPL_I2C_SEL] = i2c_select;
        pins[CPL_SCLK] = sclk_pin; // R02
        pins[CPL_DATA] = data_pin_in;
        pins[CPL_ADDR1] = addr1_or_serial_out_in;
        pins[CPL_ADDR0_CS] = addr0_or_chip_select_n;
        pins[CPL_PDN] = power_down_n;
        pins[CPL_RST] = device_reset_n;
        pins[CPL_OE] = output_enable_n;
        pins[CPL_SYNC] = output_sync_n;
        pins[CPL_INSEL0] = in_sel[0];
        pins[CPL_INSEL1] = in_sel[1];
    end

    // Reset values stand in for the pin pull resistors
    cpl_pin_sync #(
        .WIDTH(CPL_PIN_W),
        .RESET_VALUE(CPL_PIN_RESET)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pin(pins),
        .level(lvl)
    );

    // Pin reset acts through the filter, so a glitch caught by only one sample cannot wipe the device
    assign soft_rst = ~lvl[CPL_RST]; // R06
    assign logic_reset = soft_rst; // R06
    assign i2c_mode = lvl[CPL_I2C_SEL]; // R13
    assign cs_active = ~i2c_mode & ~lvl[CPL_ADDR0_CS]; // R03
    assign sel_index = {lvl[CPL_INSEL1], lvl[CPL_INSEL0]};

    // Serial side view for the protocol engine
    assign ser_i2c_mode = i2c_mode; // R13
    assign ser_spi_selected = cs_active; // R03
    assign ser_sclk = lvl[CPL_SCLK]; // R02
    assign ser_sdi = lvl[CPL_DATA]; // R14
    // Address bits mean nothing in SPI mode, so they read as zero there
    assign ser_addr = i2c_mode ? {lvl[CPL_ADDR1], lvl[CPL_ADDR0_CS]} : 2'h0; // R01

    cpl_irq_ctrl u_irq (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .soft_rst(soft_rst),
        .status(core_status),
        .clear(irq_clear),
        .pending(irq_pending),
        .irq_n(irq_n)
    );

    // Device state
    always_comb begin
        next_state = state;
        case (state)
            st_reset: begin
                next_state = lvl[CPL_PDN] ? st_run : st_power_down;
            end
            st_run: begin
                if (!lvl[CPL_PDN]) begin
                    next_state = st_power_down; // R05
                end
            end
            st_power_down: begin
                if (lvl[CPL_PDN]) begin
                    next_state = st_run;
                end
            end
            default: begin
                next_state = st_reset;
            end
        endcase
        if (soft_rst) begin
            next_state = st_reset; // R06
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= st_reset;
        end else begin
            state <= next_state;
        end
    end

    // Output control, lock, dividers and reference choice
    always_comb begin
        next_low_power_mode = (next_state == st_power_down); // R05
        // Outputs off in reset, power down or while enable pin is high
        next_clk_out_disable = (next_state != st_run) | lvl[CPL_OE]; // R07 R08
        next_pll_locked_flag = core_pll_locked & ~soft_rst; // R09
        next_divider_reset = ~lvl[CPL_SYNC] | soft_rst; // R10
        next_ref_select = '0;
        if (manual_ref_mode) begin
            next_ref_select[sel_index] = 1'b1; // R11 R12
        end else begin
            next_ref_select[core_ref_index] = 1'b1;
        end
        if (soft_rst) begin
            next_ref_select = CPL_REF_RESET; // R06
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_power_mode <= 1'b0;
            clk_out_disable <= 1'b1;
            pll_locked_flag <= 1'b0;
            divider_reset <= 1'b1;
            ref_select <= CPL_REF_RESET;
        end else begin
            low_power_mode <= next_low_power_mode;
            clk_out_disable <= next_clk_out_disable;
            pll_locked_flag <= next_pll_locked_flag;
            divider_reset <= next_divider_reset;
            ref_select <= next_ref_select;
        end
    end

    // Shared serial pins
    always_comb begin
        next_data_pin_out = 1'b0;
        next_data_pin_oe = 1'b0;
        next_addr1_out = 1'b0;
        next_addr1_oe = 1'b0;
        if (i2c_mode) begin
            // Open drain: only ever pull low
            next_data_pin_oe = core_tx_en & ~core_tx_data; // R14
        end else if (!spi_four_wire) begin
            next_data_pin_out = core_tx_data;
            next_data_pin_oe = core_tx_en & cs_active; // R14
        end else begin
            // Four-wire: data pin is input, reply leaves on address pin
            next_addr1_out = core_tx_data;
            next_addr1_oe = core_tx_en & cs_active; // R01
        end
        if (soft_rst) begin
            next_data_pin_oe = 1'b0;
            next_addr1_oe = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_pin_out <= 1'b0;
            data_pin_oe <= 1'b0;
            addr1_or_serial_out_out <= 1'b0;
            addr1_or_serial_out_oe <= 1'b0;
        end else begin
            data_pin_out <= next_data_pin_out;
            data_pin_oe <= next_data_pin_oe;
            addr1_or_serial_out_out <= next_addr1_out;
            addr1_or_serial_out_oe <= next_addr1_oe;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    AST_RESET_OFF: assert property (soft_rst |=> clk_out_disable && !pll_locked_flag) // R07
        else $error("Clock outputs not disabled during reset");

    AST_OE_HIGH: assert property (lvl[CPL_OE] |=> clk_out_disable) // R08
        else $error("Output enable high did not disable outputs");

    AST_OE_LOW: assert property // R08
        ((!lvl[CPL_OE] && lvl[CPL_PDN] && !soft_rst && state == st_run) |=> !clk_out_disable)
        else $error("Outputs stayed disabled while enabled and running");

    AST_LOCK: assert property (!soft_rst |=> pll_locked_flag == $past(core_pll_locked)) // R09
        else $error("Lock flag does not follow the loop lock state");

    AST_PDN: assert property ((!lvl[CPL_PDN] && !soft_rst) |=> low_power_mode) // R05
        else $error("Power down low did not enter low power mode");

    AST_PDN_EXIT: assert property ((lvl[CPL_PDN] && !soft_rst) |=> !low_power_mode) // R05
        else $error("Low power mode held with power down released");

    AST_SYNC: assert property (!lvl[CPL_SYNC] |=> divider_reset) // R10
        else $error("Sync low did not reset output dividers");

    AST_REF_SEL: assert property // R12
        ((manual_ref_mode && !soft_rst) |=> ref_select == (4'h1 << $past(sel_index)))
        else $error("Manual reference select decoded wrongly");

    AST_FOUR_WIRE: assert property // R14
        ((!i2c_mode && spi_four_wire) |=> !data_pin_oe)
        else $error("Data pin driven in four-wire SPI mode");

    AST_SDO_MODE: assert property // R01
        (addr1_or_serial_out_oe |-> $past(spi_four_wire) && $past(cs_active))
        else $error("Address pin driven outside four-wire SPI select");

    AST_I2C_OPEN_DRAIN: assert property // R13
        ((i2c_mode && !soft_rst) |=> !data_pin_out && !addr1_or_serial_out_oe)
        else $error("Data pin driven high in I2C mode");

    AST_CS: assert property (ser_spi_selected == (!i2c_mode && !lvl[CPL_ADDR0_CS])) // R03
        else $error("Chip select decode wrong");

    AST_RESET_DEFAULTS: assert property // R06
        (soft_rst |=> ref_select == CPL_REF_RESET && divider_reset && !data_pin_oe)
        else $error("Reset did not restore reference, dividers and data pin");

    AST_RESET_SDO: assert property // R06
        (soft_rst |=> !addr1_or_serial_out_oe && irq_n)
        else $error("Reset left the serial out pin driven or the interrupt low");

    AST_PDN_OUTS: assert property // R05
        (!lvl[CPL_PDN] |=> clk_out_disable)
        else $error("Clock outputs running in power down");

    AST_SYNC_HIGH: assert property // R10
        ((lvl[CPL_SYNC] && !soft_rst) |=> !divider_reset)
        else $error("Dividers held in reset with sync released");

    AST_AUTO_REF: assert property // R11
        ((!manual_ref_mode && !soft_rst) |=> ref_select == (4'h1 << $past(core_ref_index)))
        else $error("Automatic reference choice not followed");

    AST_REF_ONEHOT: assert property ($onehot(ref_select)) // R12
        else $error("More or less than one reference selected");

    AST_SPI_DESELECT: assert property // R03
        ((!i2c_mode && !cs_active) |=> !data_pin_oe && !addr1_or_serial_out_oe)
        else $error("Serial pin driven while SPI select is high");

    AST_SPI_TX: assert property // R14
        ((cs_active && !spi_four_wire && core_tx_en && !soft_rst) |=>
            data_pin_oe && data_pin_out == $past(core_tx_data))
        else $error("Three-wire SPI reply not driven on the data pin");

    AST_SDO_TX: assert property // R01
        ((cs_active && spi_four_wire && core_tx_en && !soft_rst) |=>
            addr1_or_serial_out_oe && addr1_or_serial_out_out == $past(core_tx_data))
        else $error("Four-wire SPI reply not driven on the serial out pin");

    AST_I2C_PULL: assert property // R14
        ((i2c_mode && core_tx_en && !core_tx_data && !soft_rst) |=> data_pin_oe)
        else $error("I2C data pin not pulled low for a zero bit");

endmodule
`default_nettype wire

// >>> cpl_host_model.sv
// Host controller model driving the control and serial port pins
`timescale 1ns/10ps
`default_nettype none
module cpl_host_model
    import cpl_pkg::*;
(
    input wire logic dev_data_oe,
    input wire logic dev_data_out,
    input wire logic dev_sdo_oe,
    input wire logic dev_sdo_out,
    output logic [CPL_PIN_W-1:0] pin,
    output logic data_wire,
    output logic addr1_wire
);
    logic host_data_oe = 1'b0;

    // Open pins sit at their pull levels, serial clock idles high
    initial pin = CPL_PIN_RESET;

    task automatic set_pin(input int idx, input logic v);
        pin[idx] = v;
    endtask

    task automatic drive_data(input logic oe);
        host_data_oe = oe;
    endtask

    // Released line: pull-up in I2C, else inverted so a stale value never passes
    always_comb begin
        if (dev_data_oe) begin
            data_wire = dev_data_out;
        end else if (host_data_oe) begin
            data_wire = pin[CPL_DATA];
        end else begin
            data_wire = pin[CPL_I2C_SEL] | ~pin[CPL_DATA];
        end
    end

    // Host sets the address only in I2C; otherwise the line reads inverted
    assign addr1_wire = dev_sdo_oe ? dev_sdo_out :
        (pin[CPL_I2C_SEL] ? pin[CPL_ADDR1] : ~pin[CPL_ADDR1]);
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the control and status pin logic
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cpl_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic manual_ref_mode = 1'b0;
    logic spi_four_wire = 1'b0;
    logic [CPL_REF_IDX_W-1:0] core_ref_index = 2'h0;
    logic core_pll_locked = 1'b0;
    logic [CPL_STATUS_W-1:0] core_status = 4'h0;
    logic [CPL_STATUS_W-1:0] irq_clear = 4'h0;
    logic core_tx_data = 1'b0;
    logic core_tx_en = 1'b0;
    logic [CPL_PIN_W-1:0] pin;
    logic data_wire, addr1_wire, data_pin_out, data_pin_oe, sdo_out, sdo_oe;
    logic irq_n, pll_locked_flag, clk_out_disable, low_power_mode, divider_reset;
    logic logic_reset, ser_i2c_mode, ser_spi_selected, ser_sclk, ser_sdi;
    logic [CPL_STATUS_W-1:0] irq_pending;
    logic [CPL_NUM_REFS-1:0] ref_select;
    logic [1:0] ser_addr;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    cpl_host_model u_host (.dev_data_oe(data_pin_oe), .dev_data_out(data_pin_out),
        .dev_sdo_oe(sdo_oe), .dev_sdo_out(sdo_out), .pin, .data_wire, .addr1_wire);

    cpl_pin_ctrl u_dut (.ref_clk, .resetn, .i2c_select(pin[CPL_I2C_SEL]),
        .sclk_pin(pin[CPL_SCLK]), .data_pin_in(data_wire), .data_pin_out, .data_pin_oe,
        .addr1_or_serial_out_in(addr1_wire), .addr1_or_serial_out_out(sdo_out),
        .addr1_or_serial_out_oe(sdo_oe), .addr0_or_chip_select_n(pin[CPL_ADDR0_CS]),
        .power_down_n(pin[CPL_PDN]), .device_reset_n(pin[CPL_RST]),
        .output_enable_n(pin[CPL_OE]), .output_sync_n(pin[CPL_SYNC]),
        .in_sel({pin[CPL_INSEL1], pin[CPL_INSEL0]}), .manual_ref_mode, .spi_four_wire,
        .core_ref_index, .core_pll_locked, .core_status, .irq_clear, .core_tx_data,
        .core_tx_en, .irq_n, .irq_pending, .pll_locked_flag, .clk_out_disable,
        .low_power_mode, .divider_reset, .ref_select, .logic_reset, .ser_i2c_mode,
        .ser_spi_selected, .ser_sclk, .ser_sdi, .ser_addr);

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Whole run needs about 130 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Pins pass a filter, so six cycles covers the four-edge latency
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic t_reset();
        check(irq_n, 1);
        check(pll_locked_flag, 0);
        check(clk_out_disable, 1);
        check(ref_select, 1);
        check(data_pin_oe | sdo_oe, 0);
    endtask

    task automatic t_pins();
        check(clk_out_disable, 0);
        check(divider_reset, 0);
        u_host.set_pin(CPL_OE, 1'b1);
        wt(6);
        check(clk_out_disable, 1);
        u_host.set_pin(CPL_OE, 1'b0);
        u_host.set_pin(CPL_PDN, 1'b0);
        u_host.set_pin(CPL_SYNC, 1'b0);
        wt(6);
        check(low_power_mode, 1);
        check(divider_reset, 1);
        u_host.set_pin(CPL_PDN, 1'b1);
        u_host.set_pin(CPL_SYNC, 1'b1);
        wt(6);
        check(low_power_mode, 0);
        check(divider_reset, 0);
        check(clk_out_disable, 0);
    endtask

    task automatic t_lock();
        core_pll_locked = 1'b1;
        wt(2);
        check(pll_locked_flag, 1);
        core_pll_locked = 1'b0;
        wt(2);
        check(pll_locked_flag, 0);
    endtask

    task automatic t_ref();
        manual_ref_mode = 1'b1;
        for (int i = 0; i < CPL_NUM_REFS; i++) begin
            u_host.set_pin(CPL_INSEL0, i[0]);
            u_host.set_pin(CPL_INSEL1, i[1]);
            wt(6);
            check(ref_select, 8'h1 << i);
        end
        manual_ref_mode = 1'b0;
        for (int i = 0; i < CPL_NUM_REFS; i++) begin
            core_ref_index = i[1:0];
            wt(2);
            check(ref_select, 8'h1 << i);
        end
    endtask

    task automatic t_serial();
        u_host.set_pin(CPL_ADDR1, 1'b1);
        u_host.set_pin(CPL_ADDR0_CS, 1'b0);
        u_host.set_pin(CPL_SCLK, 1'b0);
        wt(6);
        check(ser_i2c_mode, 1);
        check(ser_addr, 2'h2);
        check(ser_spi_selected, 0);
        check(ser_sclk, 0);
        u_host.set_pin(CPL_SCLK, 1'b1);
        u_host.set_pin(CPL_I2C_SEL, 1'b0);
        u_host.set_pin(CPL_ADDR0_CS, 1'b1);
        wt(6);
        check(ser_i2c_mode, 0);
        check(ser_addr, 0);
        check(ser_sclk, 1);
        check(ser_spi_selected, 0);
        u_host.set_pin(CPL_ADDR0_CS, 1'b0);
        wt(6);
        check(ser_spi_selected, 1);
    endtask

    task automatic t_tx();
        spi_four_wire = 1'b1;
        core_tx_en = 1'b1;
        core_tx_data = 1'b1;
        u_host.set_pin(CPL_DATA, 1'b0);
        u_host.drive_data(1'b1);
        wt(6);
        check({sdo_oe, sdo_out}, 2'h3);
        check(data_pin_oe, 0);
        check(ser_sdi, 0);
        core_tx_data = 1'b0;
        wt(2);
        check(sdo_out, 0);
        u_host.drive_data(1'b0);
        spi_four_wire = 1'b0;
        wt(2);
        check({data_pin_oe, data_pin_out}, 2'h2);
        check(sdo_oe, 0);
        u_host.set_pin(CPL_I2C_SEL, 1'b1);
        wt(6);
        check({data_pin_oe, data_pin_out}, 2'h2);
        check(sdo_oe, 0);
        core_tx_data = 1'b1;
        wt(2);
        check(data_pin_oe, 0);
        core_tx_en = 1'b0;
    endtask

    task automatic t_irq();
        check(irq_n, 1);
        core_status = 4'h5;
        wt(3);
        check(irq_n, 0);
        check(irq_pending, 4'h5);
        irq_clear = 4'h1;
        wt(1);
        irq_clear = 4'h0;
        wt(2);
        check({irq_n, irq_pending}, 5'h04);
        irq_clear = 4'h4;
        wt(1);
        irq_clear = 4'h0;
        wt(2);
        check({irq_n, irq_pending}, 5'h10);
        core_status = 4'h4;
        wt(1);
        // Toggle and clear of one bit in one cycle: the new change wins
        core_status = 4'h5;
        irq_clear = 4'h1;
        wt(1);
        check({irq_n, irq_pending}, 5'h01);
        wt(1);
        irq_clear = 4'h0;
        wt(1);
        check({irq_n, irq_pending}, 5'h10);
    endtask

    task automatic t_devrst();
        manual_ref_mode = 1'b1;
        core_pll_locked = 1'b1;
        core_status = 4'h0;
        u_host.set_pin(CPL_RST, 1'b0);
        wt(6);
        check(logic_reset, 1);
        check({irq_n, irq_pending}, 5'h10);
        check(clk_out_disable, 1);
        check(pll_locked_flag, 0);
        check(ref_select, 1);
        u_host.set_pin(CPL_RST, 1'b1);
        wt(7);
        check(logic_reset, 0);
        check(clk_out_disable, 0);
        check(pll_locked_flag, 1);
        check(ref_select, 8'h8);
    endtask

    initial begin
        repeat (10) @(negedge ref_clk);
        t_reset();
        resetn = 1'b1;
        wt(6);
        t_pins();
        t_lock();
        t_ref();
        t_serial();
        t_tx();
        t_irq();
        t_devrst();
        wrap_up();
    end
endmodule
`default_nettype wire
